// [logic/sie_pkg.sv]
// constants for the subtract instruction execution block
//------------------------------------------------------------
// Behaviour
// [RULE1] The register-subtract instruction (0101 11da ffff ffff) computes the file register minus the accumulator in two's complement.
// [RULE2] With the destination bit at 0 the register-subtract result goes to the accumulator and the file register is left as it was.
// [RULE3] With the destination bit at 1 the register-subtract result is written back into the addressed file register.
// [RULE4] With the bank-access bit at 0 the fixed access bank is addressed and the bank select register is ignored.
// [RULE5] With the bank-access bit at 1 the address is the bank select register value joined with the 8-bit address field.
// [RULE6] The literal-subtract instruction (0000 1000 kkkk kkkk) computes the literal minus the accumulator into the accumulator in one cycle.
// [RULE7] Both instructions update the negative, overflow, carry, digit-carry and zero flags, carry meaning no borrow,
// with the result written in the fourth phase; the code strobes memWrEn for a file destination in the cycle after the write phase.
//------------------------------------------------------------
package sie_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_BANK   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // instruction word decode
  localparam logic [7:0] OPC_SUBLIT  = 8'h08;  // upper byte of literal subtract
  localparam logic [5:0] OPC_SUBFILE = 6'h17;  // upper six bits of register subtract
  localparam int         BIT_DEST    = 9;
  localparam int         BIT_BANKSEL = 8;

  // status field positions
  localparam int STS_CARRY  = 0;
  localparam int STS_DIGIT  = 1;
  localparam int STS_ZERO   = 2;
  localparam int STS_OVFL   = 3;
  localparam int STS_NEG    = 4;
  localparam int STS_BUSY   = 5;
  localparam int STS_BADOP  = 6;

  // reset values
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;

  // execution phases of one instruction cycle
  typedef enum logic [2:0] {
    SIE_IDLE,
    SIE_DECODE,
    SIE_READ,
    SIE_PROCESS,
    SIE_WRITE
  } sie_phase_t;

endpackage

// [logic/sie_subtract_exec.sv]
// subtract instruction execution unit with apb register access
`timescale 1ns/1ps
`default_nettype none

module sie_subtract_exec #(
  parameter int BANK_BITS = 4
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // data memory port
  output logic [BANK_BITS+7:0]           memAddr,
  output logic                           memRdEn,
  input  wire logic [7:0]                memRdData,
  output logic                           memWrEn,
  output logic [7:0]                     memWrData,
  // core state view
  output logic [7:0]                     accOut,
  output logic                           overflowFlagOut,
  output logic                           digitCarryFlagOut,
  output logic                           carryOut,
  output logic                           zeroOut,
  output logic                           negOut,
  output logic                           execDone
);

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  sie_pkg::sie_phase_t phase_reg;
  logic [15:0]          instr_reg;
  logic [7:0]           acc_reg;
  logic [BANK_BITS-1:0] bank_select_reg;
  logic [7:0]           operand_reg;
  logic [7:0]           result_reg;
  logic                 destFile_reg;
  logic                 badOp_reg;
  logic                 carry_reg;
  logic                 digitCarry_reg;
  logic                 zero_reg;
  logic                 ovfl_reg;
  logic                 neg_reg;

  //------------------------------------------------------------
  // apb decode
  //------------------------------------------------------------
  logic apbAccess;
  logic apbDone;
  logic busy;
  logic wrInstr;
  logic wrAcc;
  logic wrBank;
  logic badWrite;

  // busy while an instruction is in flight
  assign busy      = (phase_reg != sie_pkg::SIE_IDLE);
  assign apbAccess = psel & penable;
  // a transfer completes at the edge where pready is seen high
  assign apbDone   = apbAccess & pready;
  assign wrInstr   = apbDone & pwrite & (paddr == sie_pkg::OFS_INSTR) & ~busy;
  assign wrAcc     = apbDone & pwrite & (paddr == sie_pkg::OFS_ACC) & ~busy;
  assign wrBank    = apbDone & pwrite & (paddr == sie_pkg::OFS_BANK) & ~busy;
  // writes while busy, to status or unmapped are refused
  assign badWrite  = pwrite & (busy | ((paddr != sie_pkg::OFS_INSTR) & (paddr != sie_pkg::OFS_ACC)
                     & (paddr != sie_pkg::OFS_BANK)));

  // instruction decode
  logic isLit;
  logic isFile;
  assign isLit  = (instr_reg[15:8] == sie_pkg::OPC_SUBLIT);
  assign isFile = (instr_reg[15:10] == sie_pkg::OPC_SUBFILE);

  // file register address from bank bit and address field
  logic [BANK_BITS+7:0] fileAddr;
  always_comb begin
    if (instr_reg[sie_pkg::BIT_BANKSEL]) begin
      fileAddr = {bank_select_reg, instr_reg[7:0]};  // [RULE5]
    end else if (instr_reg[7]) begin
      fileAddr = {{BANK_BITS{1'b1}}, instr_reg[7:0]}; // [RULE4] upper access half: top bank
    end else begin
      fileAddr = {{BANK_BITS{1'b0}}, instr_reg[7:0]}; // [RULE4] lower access half: bank 0
    end
  end

  // subtraction operand minus accumulator and its flags
  logic [8:0] diff;
  logic [4:0] nibDiff;
  logic [7:0] res;
  assign diff    = {1'b0, operand_reg} - {1'b0, acc_reg};           // [RULE1] [RULE6]
  assign nibDiff = {1'b0, operand_reg[3:0]} - {1'b0, acc_reg[3:0]};
  assign res     = diff[7:0];

  //------------------------------------------------------------
  // apb answer
  //------------------------------------------------------------
  // pready rises one cycle into the access phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= apbAccess & ~pready;
    end
  end

  // read data and error are loaded with pready
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apbAccess & ~pready) begin
      pslverr <= badWrite | (~pwrite & (paddr != sie_pkg::OFS_INSTR) & (paddr != sie_pkg::OFS_ACC)
                 & (paddr != sie_pkg::OFS_BANK) & (paddr != sie_pkg::OFS_STATUS));
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end else if (paddr == sie_pkg::OFS_INSTR) begin
        prdata <= {16'h0000, instr_reg};
      end else if (paddr == sie_pkg::OFS_ACC) begin
        prdata <= {24'h000000, acc_reg};
      end else if (paddr == sie_pkg::OFS_BANK) begin
        prdata <= {{(32-BANK_BITS){1'b0}}, bank_select_reg};
      end else if (paddr == sie_pkg::OFS_STATUS) begin
        prdata <= {25'h0, badOp_reg, busy, neg_reg, ovfl_reg, zero_reg, digitCarry_reg, carry_reg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else begin
      pslverr <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // software registers
  //------------------------------------------------------------
  // instruction word, a write launches execution
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      instr_reg <= sie_pkg::INSTR_RESET;
    end else if (wrInstr) begin
      instr_reg <= pwdata[15:0];
    end
  end

  // bank select register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bank_select_reg <= '0;
    end else if (wrBank) begin
      bank_select_reg <= pwdata[BANK_BITS-1:0];
    end
  end

  //------------------------------------------------------------
  // four phase sequencer
  //------------------------------------------------------------
  // decode, read, process, write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= sie_pkg::SIE_IDLE;
    end else begin
      case (phase_reg)
        sie_pkg::SIE_IDLE: begin
          if (wrInstr) begin
            phase_reg <= sie_pkg::SIE_DECODE;
          end
        end
        sie_pkg::SIE_DECODE: begin
          phase_reg <= (isLit | isFile) ? sie_pkg::SIE_READ : sie_pkg::SIE_IDLE;
        end
        sie_pkg::SIE_READ: begin
          phase_reg <= sie_pkg::SIE_PROCESS;
        end
        sie_pkg::SIE_PROCESS: begin
          phase_reg <= sie_pkg::SIE_WRITE;
        end
        default: begin
          phase_reg <= sie_pkg::SIE_IDLE;
        end
      endcase
    end
  end

  // unknown opcode flag, refreshed on each decode
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      badOp_reg <= 1'b0;
    end else if (phase_reg == sie_pkg::SIE_DECODE) begin
      badOp_reg <= ~(isLit | isFile);
    end
  end

  // memory read issued in the read phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      memRdEn <= 1'b0;
      memAddr <= '0;
    end else begin
      memRdEn <= (phase_reg == sie_pkg::SIE_DECODE) & isFile;  // [RULE1]
      if (phase_reg == sie_pkg::SIE_DECODE) begin
        memAddr <= fileAddr;                                   // [RULE4] [RULE5]
      end
    end
  end

  // operand: literal field or read data, destination choice
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      operand_reg  <= 8'h00;
      destFile_reg <= 1'b0;
    end else if (phase_reg == sie_pkg::SIE_DECODE) begin
      operand_reg  <= instr_reg[7:0];                                  // [RULE6]
      destFile_reg <= isFile & instr_reg[sie_pkg::BIT_DEST];           // [RULE2] [RULE3]
    end else if ((phase_reg == sie_pkg::SIE_PROCESS) & isFile) begin
      operand_reg  <= memRdData;                                       // [RULE1]
    end
  end

  // result latched at the end of write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      result_reg <= 8'h00;
    end else if (phase_reg == sie_pkg::SIE_WRITE) begin
      result_reg <= res;
    end
  end

  // write phase: destination update
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      memWrEn   <= 1'b0;
    end else begin
      memWrEn   <= (phase_reg == sie_pkg::SIE_WRITE) & destFile_reg;  // [RULE3] [RULE7]
    end
  end

  // write data is the latched result, held steady after the strobe
  assign memWrData = result_reg;                                   // [RULE1] [RULE3]

  // accumulator: software write or instruction result
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= sie_pkg::ACC_RESET;
    end else if ((phase_reg == sie_pkg::SIE_WRITE) & ~destFile_reg) begin
      acc_reg <= res;                                                  // [RULE2] [RULE6]
    end else if (wrAcc) begin
      acc_reg <= pwdata[7:0];
    end
  end

  // arithmetic flags, carry means no borrow
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      carry_reg      <= 1'b0;
      digitCarry_reg <= 1'b0;
      zero_reg       <= 1'b0;
      ovfl_reg       <= 1'b0;
      neg_reg        <= 1'b0;
    end else if (phase_reg == sie_pkg::SIE_WRITE) begin
      carry_reg      <= ~diff[8];                                       // [RULE7]
      digitCarry_reg <= ~nibDiff[4];                                    // [RULE7]
      zero_reg       <= (res == 8'h00);                                 // [RULE7]
      ovfl_reg       <= (operand_reg[7] ^ acc_reg[7]) & (res[7] ^ operand_reg[7]); // [RULE7]
      neg_reg        <= res[7];                                         // [RULE7]
    end
  end

  // completion pulse after the write phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      execDone <= 1'b0;
    end else begin
      execDone <= (phase_reg == sie_pkg::SIE_WRITE);
    end
  end

  //------------------------------------------------------------
  // state view outputs
  //------------------------------------------------------------
  // registered copies of core state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      accOut            <= sie_pkg::ACC_RESET;
      overflowFlagOut   <= 1'b0;
      digitCarryFlagOut <= 1'b0;
      carryOut          <= 1'b0;
      zeroOut           <= 1'b0;
      negOut            <= 1'b0;
    end else begin
      accOut            <= acc_reg;
      overflowFlagOut   <= ovfl_reg;
      digitCarryFlagOut <= digitCarry_reg;
      carryOut          <= carry_reg;
      zeroOut           <= zero_reg;
      negOut            <= neg_reg;
    end
  end

endmodule

`default_nettype wire

// [verification/sie_subtract_exec_monitor.sv]
// protocol and sequencing checker for the subtract execution unit
`timescale 1ns/1ps
`default_nettype none

module sie_subtract_exec_monitor #(
  parameter int BANK_BITS = 4
) (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  // apb slave
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  // data memory port
  input wire logic [BANK_BITS+7:0] memAddr,
  input wire logic                 memRdEn,
  input wire logic [7:0]           memRdData,
  input wire logic                 memWrEn,
  input wire logic [7:0]           memWrData,
  // core state view
  input wire logic [7:0]           accOut,
  input wire logic                 overflowFlagOut,
  input wire logic                 digitCarryFlagOut,
  input wire logic                 carryOut,
  input wire logic                 zeroOut,
  input wire logic                 negOut,
  input wire logic                 execDone
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  //----------------------------------------------------------
  // sequences
  //----------------------------------------------------------
  sequence s_access_start;
    psel && $rose(penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  sequence s_read_phase;
    memRdEn;
  endsequence
  sequence s_result_phase;
    ##3 execDone;
  endsequence

  //----------------------------------------------------------
  // assertions
  //----------------------------------------------------------
  chk_apb_wait: assert property (s_access_start |-> s_one_wait)
    else $error("apb answer not after exactly one wait state");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_slverr_qual: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completing transfer");
  chk_rd_to_done: assert property (s_read_phase |-> s_result_phase)
    else $error("result phase not three cycles after operand read");
  chk_rd_pulse: assert property (memRdEn |=> !memRdEn)
    else $error("operand read longer than one cycle");
  chk_wr_after_rd: assert property (memWrEn |-> $past(memRdEn, 3))
    else $error("file write without operand read three cycles earlier");
  chk_wr_with_done: assert property (memWrEn |-> execDone)
    else $error("file write outside the result phase");
  chk_done_pulse: assert property (execDone |=> !execDone)
    else $error("completion pulse longer than one cycle");
  chk_addr_held: assert property (memRdEn |=> $stable(memAddr) [*3])
    else $error("write back address differs from read address");
  chk_flags_only_exec: assert property ($changed({negOut, overflowFlagOut, zeroOut, digitCarryFlagOut,
    carryOut}) |-> execDone || $past(execDone))
    else $error("flags changed without an executed subtract");
endmodule

bind sie_subtract_exec sie_subtract_exec_monitor #(.BANK_BITS(BANK_BITS)) u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .memAddr(memAddr), .memRdEn(memRdEn),
  .memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData), .accOut(accOut),
  .overflowFlagOut(overflowFlagOut), .digitCarryFlagOut(digitCarryFlagOut), .carryOut(carryOut),
  .zeroOut(zeroOut), .negOut(negOut), .execDone(execDone));

`default_nettype wire

// [verification/tb.sv]
// self-checking testbench for the subtract execution unit
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {logic rg; logic wr; logic [11:0] ad; logic [7:0] dat;
                         logic [7:0] acc; logic [4:0] flg;} sie_exp_t;
  logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, memRdData = 8'h5a;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, memRdEn, memWrEn, overflowFlagOut, digitCarryFlagOut, carryOut, zeroOut, negOut, execDone;
  logic err;
  logic [11:0] memAddr;
  logic [7:0] memWrData, accOut;
  logic [7:0] mem [4096];
  sie_exp_t expq[$];
  sie_exp_t e;
  sie_exp_t got;
  int failures = 0, n_checks = 0, cycles = 0;

  sie_subtract_exec #(.BANK_BITS(4)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .memAddr(memAddr), .memRdEn(memRdEn), .memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData),
    .accOut(accOut), .overflowFlagOut(overflowFlagOut), .digitCarryFlagOut(digitCarryFlagOut),
    .carryOut(carryOut), .zeroOut(zeroOut), .negOut(negOut), .execDone(execDone));

  // clock and cycle ceiling
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // synchronous data memory, one cycle latency, scrambled when idle
  always @(posedge clk_sys) begin
    memRdData <= (memRdEn === 1'b1) ? mem[memAddr] : ~memRdData;
    if (memWrEn === 1'b1) mem[memAddr] <= memWrData;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // run one subtract, noting the expected pin results
  task automatic run_op(input logic [15:0] ins, input logic [7:0] acc, input logic [3:0] bank);
    logic [7:0] opnd, res;
    int sd;
    e = '0;
    e.rg = (ins[15:8] !== sie_pkg::OPC_SUBLIT);
    e.ad = ins[8] ? {bank, ins[7:0]} : {{4{ins[7]}}, ins[7:0]};
    opnd = ins[7:0];
    if (e.rg) begin
      opnd = 8'($urandom);
      mem[e.ad] = opnd;
    end
    res = opnd - acc;
    sd = $signed(opnd) - $signed(acc);
    e.wr = e.rg && ins[9];
    e.dat = res;
    e.acc = e.wr ? acc : res;
    e.flg = {res[7], (sd > 127) || (sd < -128), res == 8'h00, opnd[3:0] >= acc[3:0], opnd >= acc};
    expq.push_back(e);
    apb(1'b1, sie_pkg::OFS_ACC, {24'h0, acc});
    apb(1'b1, sie_pkg::OFS_BANK, {28'h0, bank});
    apb(1'b1, sie_pkg::OFS_INSTR, {16'h0, ins});
    // accumulator write while busy must be refused and leave the result alone
    apb(1'b1, sie_pkg::OFS_ACC, {24'h0, ~acc});
    check(err, 1'b1);
    do apb(1'b0, sie_pkg::OFS_STATUS, 32'h0); while (rd[sie_pkg::STS_BUSY] !== 1'b0);
    check(rd[4:0], e.flg);
    apb(1'b0, sie_pkg::OFS_ACC, 32'h0);
    check(rd, {24'h0, e.acc});
  endtask

  // watcher: compares pin results at each completion pulse
  always @(posedge clk_sys) begin
    if (execDone === 1'b1) begin
      got = expq.pop_front();
      check(memWrEn, got.wr);
      if (got.rg) check(memAddr, got.ad);
      if (got.wr) check(memWrData, got.dat);
      repeat (2) @(posedge clk_sys);
      check(accOut, got.acc);
      check({negOut, overflowFlagOut, zeroOut, digitCarryFlagOut, carryOut}, got.flg);
    end
  end

  // main sequence
  initial begin
    void'($urandom(18));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, sie_pkg::OFS_ACC, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, sie_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    for (int i = 1; i <= 3; i++) run_op({sie_pkg::OPC_SUBLIT, 8'h02}, i[7:0], 4'h0);
    repeat (6) run_op({sie_pkg::OPC_SUBLIT, 8'($urandom)}, 8'($urandom), 4'($urandom));
    $display("test literal subtract done");
    for (int i = 0; i < 16; i++) begin
      run_op({sie_pkg::OPC_SUBFILE, i[1:0], 8'($urandom)}, 8'($urandom), 4'($urandom));
    end
    $display("test register subtract done");
    apb(1'b1, sie_pkg::OFS_STATUS, 32'h7f);
    check(err, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b0, sie_pkg::OFS_STATUS, 32'h0);
    e.flg = rd[4:0];
    apb(1'b1, sie_pkg::OFS_INSTR, 32'hffff);
    repeat (6) @(posedge clk_sys);
    apb(1'b0, sie_pkg::OFS_STATUS, 32'h0);
    check({rd[sie_pkg::STS_BADOP], rd[4:0]}, {1'b1, e.flg});
    check(expq.size(), 0);
    $display("test refusals done");
    give_verdict();
  end
endmodule

`default_nettype wire
